// >>> src/logger_ctrl_pkg.sv
// Package: register offsets, field positions, reset values and carrier types
package logger_ctrl_pkg;
	localparam logic [9:0] TEMP_ALARM_ENABLE_CTRL_OFFS = 10'h210;
	localparam logic [9:0] DATA_ALARM_ENABLE_CTRL_OFFS = 10'h211;
	localparam logic [9:0] CLOCK_CONTROL_OFFS = 10'h212;
	localparam logic [9:0] MISSION_CONTROL_OFFS = 10'h213;
	localparam logic [9:0] DATA_LOW_THRESH_OFFS = 10'h20a;
	localparam logic [9:0] DATA_HIGH_THRESH_OFFS = 10'h20b;
	localparam logic [9:0] ALARM_STATUS_OFFS = 10'h214;
	localparam logic [9:0] TEMP_LOW_THRESH_OFFS = 10'h208;
	localparam logic [9:0] TEMP_HIGH_THRESH_OFFS = 10'h209;
	// Writable masks and constant bits of the control and status registers
	localparam logic [7:0] TEMP_EN_MASK = 8'h03;
	localparam logic [7:0] TEMP_EN_FIXED = 8'h00;
	localparam logic [7:0] DATA_EN_MASK = 8'h03;
	localparam logic [7:0] DATA_EN_FIXED = 8'hfc;
	localparam logic [7:0] CLK_CTRL_MASK = 8'h03;
	localparam logic [7:0] CLK_CTRL_FIXED = 8'h00;
	localparam logic [7:0] MISSION_MASK = 8'h3f;
	localparam logic [7:0] MISSION_FIXED = 8'hc0;
	localparam logic [7:0] STATUS_FIXED = 8'h70;
	// Field positions
	localparam int LOW_ALARM_BIT = 0;
	localparam int HIGH_ALARM_BIT = 1;
	localparam int OSC_ENABLE_BIT = 0;
	localparam int SAMPLE_UNIT_BIT = 1;
	localparam int LOG_TEMP_BIT = 0;
	localparam int LOG_SERIAL_BIT = 1;
	localparam int TEMP_WIDE_BIT = 2;
	localparam int SERIAL_WIDE_BIT = 3;
	localparam int WRAP_BIT = 4;
	localparam int START_ON_ALARM_BIT = 5;
	// Reset values
	localparam logic [7:0] TEMP_EN_RESET = 8'h00;
	localparam logic [7:0] DATA_EN_RESET = 8'hfc;
	localparam logic [7:0] CLK_CTRL_RESET = 8'h00;
	localparam logic [7:0] MISSION_RESET = 8'hc0;
	localparam logic [7:0] THRESH_RESET = 8'h00;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic valid;
		logic [15:0] value;
	} sample_s;

	typedef struct packed {
		logic osc_enable;
		logic sample_unit_seconds;
		logic log_temperature_en;
		logic log_serial_input_en;
		logic temp_wide_format;
		logic serial_wide_format;
		logic wrap_when_full;
		logic start_on_alarm;
	} ctrl_view_s;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WAIT_ALARM = 4'b0010,
		ST_LOGGING = 4'b0100,
		ST_FULL = 4'b1000
	} mission_state_e;
endpackage

// >>> src/logger_mission_control_regs.sv
// Mission control register bank of the datalogger with alarm flag logic
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module logger_mission_control_regs
	import logger_ctrl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [9:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic start_mission_i,
	input wire logic stop_mission_i,
	input wire logic forced_conv_i,
	input wire logic clear_flags_i,
	input wire logic temp_valid_i,
	input wire logic [15:0] temp_value_i,
	input wire logic serial_valid_i,
	input wire logic [15:0] serial_value_i,
	input wire logic memory_full_i,
	output logic mission_active_o,
	output logic recording_o,
	output logic conversions_on_o,
	output logic log_temperature_o,
	output logic log_serial_input_o,
	output logic temp_wide_format_o,
	output logic serial_wide_format_o,
	output logic wrap_when_full_o,
	output logic osc_enable_o,
	output logic sample_unit_seconds_o,
	output logic [3:0] alarm_flags_o
);
	import logger_ctrl_pkg::*;

	// ==========================================================
	// Registers
	logic [7:0] temp_en_ff;
	logic [7:0] data_en_ff;
	logic [7:0] clk_ctrl_ff;
	logic [7:0] mission_ff;
	logic [7:0] temp_low_th_ff;
	logic [7:0] temp_high_th_ff;
	logic [7:0] data_low_th_ff;
	logic [7:0] data_high_th_ff;
	logic [3:0] flags_ff;
	logic [7:0] rdata_ff;
	mission_state_e state_ff;
	mission_state_e nxt_state;
	reg_req_s req;
	sample_s temp_s;
	sample_s serial_s;
	ctrl_view_s view_ff;

	// Merge a write into a register, keeping fixed bits constant
	function automatic logic [7:0] merge_bits(input logic [7:0] wd, input logic [7:0] mask,
		input logic [7:0] fixed);
		merge_bits = (wd & mask) | fixed;
	endfunction

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
	assign temp_s = '{valid: temp_valid_i, value: temp_value_i};
	assign serial_s = '{valid: serial_valid_i, value: serial_value_i};

	// ==========================================================
	// Decode
	// Offsets are compared once here; write and read paths share the selects
	function automatic logic addr_is(input logic [9:0] a, input logic [9:0] offs);
		addr_is = (a == offs);
	endfunction

	wire sel_temp_en = addr_is(req.addr, TEMP_ALARM_ENABLE_CTRL_OFFS);
	wire sel_data_en = addr_is(req.addr, DATA_ALARM_ENABLE_CTRL_OFFS);
	wire sel_clk = addr_is(req.addr, CLOCK_CONTROL_OFFS);
	wire sel_mission = addr_is(req.addr, MISSION_CONTROL_OFFS);
	wire sel_tlo = addr_is(req.addr, TEMP_LOW_THRESH_OFFS);
	wire sel_thi = addr_is(req.addr, TEMP_HIGH_THRESH_OFFS);
	wire sel_dlo = addr_is(req.addr, DATA_LOW_THRESH_OFFS);
	wire sel_dhi = addr_is(req.addr, DATA_HIGH_THRESH_OFFS);
	wire sel_status = addr_is(req.addr, ALARM_STATUS_OFFS);

	// Wait and full states still count as a mission, so the lock holds there too
	wire in_mission = (state_ff != ST_IDLE);
	wire wr_ok = req.wr && !in_mission;
	wire wr_temp_en = wr_ok && sel_temp_en;
	wire wr_data_en = wr_ok && sel_data_en;
	wire wr_clk = wr_ok && sel_clk;
	wire wr_mission = wr_ok && sel_mission;
	// Thresholds share the mission lock so a run uses stable limits
	wire wr_tlo = wr_ok && sel_tlo;
	wire wr_thi = wr_ok && sel_thi;
	wire wr_dlo = wr_ok && sel_dlo;
	wire wr_dhi = wr_ok && sel_dhi;

	wire [7:0] status_view = STATUS_FIXED | {4'h0, flags_ff};
	logic [7:0] rd_mux;
	always_comb
	begin
		if (sel_temp_en)
			rd_mux = temp_en_ff;
		else if (sel_data_en)
			rd_mux = data_en_ff;
		else if (sel_clk)
			rd_mux = clk_ctrl_ff;
		else if (sel_mission)
			rd_mux = mission_ff;
		else if (sel_tlo)
			rd_mux = temp_low_th_ff;
		else if (sel_thi)
			rd_mux = temp_high_th_ff;
		else if (sel_dlo)
			rd_mux = data_low_th_ff;
		else if (sel_dhi)
			rd_mux = data_high_th_ff;
		else if (sel_status)
			rd_mux = status_view;
		else
			rd_mux = 8'h00;
	end

	// ==========================================================
	// Alarm comparisons
	wire [7:0] temp_msb = temp_s.value[15:8];
	wire [7:0] serial_msb = serial_s.value[15:8];
	wire temp_lo_hit = temp_s.valid && (temp_msb <= temp_low_th_ff);
	wire temp_hi_hit = temp_s.valid && (temp_msb >= temp_high_th_ff);
	// Forced conversions may also touch the flags
	wire alarm_window = in_mission || forced_conv_i;
	wire set_tlf = alarm_window && temp_lo_hit && temp_en_ff[LOW_ALARM_BIT];
	wire set_thf = alarm_window && temp_hi_hit && temp_en_ff[HIGH_ALARM_BIT];
	// Serial compares mirror the temperature path on the high byte
	wire serial_lo_hit = serial_s.valid && (serial_msb <= data_low_th_ff);
	wire serial_hi_hit = serial_s.valid && (serial_msb >= data_high_th_ff);
	wire set_dlf = alarm_window && serial_lo_hit && data_en_ff[LOW_ALARM_BIT];
	wire set_dhf = alarm_window && serial_hi_hit && data_en_ff[HIGH_ALARM_BIT];
	wire [3:0] flag_set = {set_dhf, set_dlf, set_thf, set_tlf};
	// Set wins over clear
	wire [3:0] nxt_flags = (clear_flags_i ? 4'h0 : flags_ff) | flag_set;
	wire temp_alarm_now = set_tlf || set_thf;

	// ==========================================================
	// Mission sequencing
	// A refused start leaves both the state and the oscillator alone
	wire start_ok = start_mission_i && !in_mission
		&& (mission_ff[LOG_TEMP_BIT] || mission_ff[LOG_SERIAL_BIT]);
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (start_ok)
					nxt_state = mission_ff[START_ON_ALARM_BIT] ? ST_WAIT_ALARM : ST_LOGGING;
			ST_WAIT_ALARM:
				if (stop_mission_i)
					nxt_state = ST_IDLE;
				else if (temp_alarm_now)
					nxt_state = ST_LOGGING;
			ST_LOGGING:
				if (stop_mission_i)
					nxt_state = ST_IDLE;
				else if (memory_full_i && !mission_ff[WRAP_BIT])
					nxt_state = ST_FULL;
			ST_FULL:
				if (stop_mission_i)
					nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// ==========================================================
	// Register update
	// Masked write values; fixed bits never reach the flops from the bus
	wire [7:0] temp_en_wval = merge_bits(req.wdata, TEMP_EN_MASK, TEMP_EN_FIXED);
	wire [7:0] data_en_wval = merge_bits(req.wdata, DATA_EN_MASK, DATA_EN_FIXED);
	wire [7:0] clk_ctrl_wval = merge_bits(req.wdata, CLK_CTRL_MASK, CLK_CTRL_FIXED);
	wire [7:0] mission_wval = merge_bits(req.wdata, MISSION_MASK, MISSION_FIXED);
	// A command wins over a same-cycle write so the clock is sure to run
	wire osc_cmd = start_ok || forced_conv_i;
	wire [7:0] clk_ctrl_started = clk_ctrl_ff | 8'h01;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			temp_en_ff <= TEMP_EN_RESET;
			data_en_ff <= DATA_EN_RESET;
			mission_ff <= MISSION_RESET;
			temp_low_th_ff <= THRESH_RESET;
			temp_high_th_ff <= THRESH_RESET;
			data_low_th_ff <= THRESH_RESET;
			data_high_th_ff <= THRESH_RESET;
			flags_ff <= FLAGS_RESET;
			state_ff <= ST_IDLE;
			rdata_ff <= 8'h00;
		end
		else
		begin
			if (wr_temp_en)
				temp_en_ff <= temp_en_wval;
			if (wr_data_en)
				data_en_ff <= data_en_wval;
			if (wr_mission)
				mission_ff <= mission_wval;
			if (wr_tlo)
				temp_low_th_ff <= req.wdata;
			if (wr_thi)
				temp_high_th_ff <= req.wdata;
			if (wr_dlo)
				data_low_th_ff <= req.wdata;
			if (wr_dhi)
				data_high_th_ff <= req.wdata;
			flags_ff <= nxt_flags;
			state_ff <= nxt_state;
			rdata_ff <= req.rd ? rd_mux : 8'h00;
		end
	end

	// Clock control kept apart: commands may set the oscillator bit
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			clk_ctrl_ff <= CLK_CTRL_RESET;
		else if (osc_cmd)
			clk_ctrl_ff <= clk_ctrl_started;
		else if (wr_clk)
			clk_ctrl_ff <= clk_ctrl_wval;
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			view_ff <= '0;
		else
			view_ff <= '{osc_enable: clk_ctrl_ff[OSC_ENABLE_BIT],
				sample_unit_seconds: clk_ctrl_ff[SAMPLE_UNIT_BIT],
				log_temperature_en: mission_ff[LOG_TEMP_BIT],
				log_serial_input_en: mission_ff[LOG_SERIAL_BIT],
				temp_wide_format: mission_ff[TEMP_WIDE_BIT],
				serial_wide_format: mission_ff[SERIAL_WIDE_BIT],
				wrap_when_full: mission_ff[WRAP_BIT],
				start_on_alarm: mission_ff[START_ON_ALARM_BIT]};
	end

	// Status outputs load from the next state so they move with state_ff
	logic active_ff;
	logic rec_ff;
	logic conv_ff;
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			active_ff <= 1'b0;
			rec_ff <= 1'b0;
			conv_ff <= 1'b0;
		end
		else
		begin
			active_ff <= (nxt_state != ST_IDLE);
			rec_ff <= (nxt_state == ST_LOGGING);
			// Conversions halt once full without wrap; the clock keeps running
			conv_ff <= (nxt_state == ST_LOGGING) || (nxt_state == ST_WAIT_ALARM);
		end
	end

	assign rdata_o = rdata_ff;
	assign mission_active_o = active_ff;
	assign recording_o = rec_ff;
	assign conversions_on_o = conv_ff;
	assign log_temperature_o = view_ff.log_temperature_en;
	assign log_serial_input_o = view_ff.log_serial_input_en;
	assign temp_wide_format_o = view_ff.temp_wide_format;
	assign serial_wide_format_o = view_ff.serial_wide_format;
	assign wrap_when_full_o = view_ff.wrap_when_full;
	assign osc_enable_o = view_ff.osc_enable;
	assign sample_unit_seconds_o = view_ff.sample_unit_seconds;
	assign alarm_flags_o = flags_ff;
endmodule

// >>> bench/logger_mission_control_regs_chk.sv
// Port checker for the mission control register bank
`timescale 1ns/1ps
module logger_mission_control_regs_chk
	import logger_ctrl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [9:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic start_mission_i,
	input wire logic stop_mission_i,
	input wire logic forced_conv_i,
	input wire logic clear_flags_i,
	input wire logic temp_valid_i,
	input wire logic serial_valid_i,
	input wire logic mission_active_o,
	input wire logic wrap_when_full_o,
	input wire logic osc_enable_o,
	input wire logic [3:0] alarm_flags_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ==========
	// Assertions
	a_rdata_quiet: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_temp_en_fixed: assert property (rd_i && addr_i == TEMP_ALARM_ENABLE_CTRL_OFFS
		|=> rdata_o[7:2] == 6'h00) else $error("temp enable upper bits not zero");
	a_data_en_fixed: assert property (rd_i && addr_i == DATA_ALARM_ENABLE_CTRL_OFFS
		|=> rdata_o[7:2] == 6'h3f) else $error("data enable upper bits not one");
	a_clk_ctrl_fixed: assert property (rd_i && addr_i == CLOCK_CONTROL_OFFS
		|=> rdata_o[7:2] == 6'h00) else $error("clock control upper bits not zero");
	a_mission_fixed: assert property (rd_i && addr_i == MISSION_CONTROL_OFFS
		|=> rdata_o[7:6] == 2'h3) else $error("mission control upper bits not one");
	a_osc_auto_start: assert property (forced_conv_i |-> ##2 osc_enable_o)
		else $error("oscillator not started by forced conversion");
	a_osc_on_mission: assert property ($rose(mission_active_o) |-> ##1 osc_enable_o)
		else $error("oscillator not started by mission start");
	// Active output moves with the mission state; the cycles around a stop are still skipped
	a_lock_in_mission: assert property (mission_active_o && !stop_mission_i
		&& !$past(stop_mission_i) && wr_i && addr_i == MISSION_CONTROL_OFFS
		|-> ##2 $stable(wrap_when_full_o)) else $error("mission write accepted");
	a_low_flag_cause: assert property ($rose(alarm_flags_o[0]) |-> $past(temp_valid_i))
		else $error("temp low flag without conversion");
	a_high_flag_cause: assert property ($rose(alarm_flags_o[1]) |-> $past(temp_valid_i))
		else $error("temp high flag without conversion");
	a_in_low_cause: assert property ($rose(alarm_flags_o[2]) |-> $past(serial_valid_i))
		else $error("input low flag without reading");
	a_in_high_cause: assert property ($rose(alarm_flags_o[3]) |-> $past(serial_valid_i))
		else $error("input high flag without reading");
	a_flags_clear: assert property (clear_flags_i && !temp_valid_i && !serial_valid_i
		|=> alarm_flags_o == 4'h0) else $error("flags not cleared");
	c_mission: cover property ($rose(mission_active_o));
	c_all_flags: cover property (alarm_flags_o == 4'hf);
	c_locked_write: cover property (mission_active_o && wr_i);
	c_refused_start: cover property (start_mission_i && !mission_active_o ##1 !mission_active_o);
endmodule
bind logger_mission_control_regs logger_mission_control_regs_chk logger_mission_control_regs_chk_inst (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .start_mission_i(start_mission_i), .stop_mission_i(stop_mission_i),
	.forced_conv_i(forced_conv_i), .clear_flags_i(clear_flags_i), .temp_valid_i(temp_valid_i),
	.serial_valid_i(serial_valid_i), .mission_active_o(mission_active_o),
	.wrap_when_full_o(wrap_when_full_o), .osc_enable_o(osc_enable_o),
	.alarm_flags_o(alarm_flags_o)
);

// >>> bench/test_logger_mission_control_regs.sv
// Self-checking bench for the mission control register bank
`timescale 1ns/1ps
module test_logger_mission_control_regs;
	import logger_ctrl_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [9:0] addr_i = 10'h000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0, rd_i = 1'b0, start_mission_i = 1'b0, stop_mission_i = 1'b0;
	logic forced_conv_i = 1'b0, clear_flags_i = 1'b0, temp_valid_i = 1'b0;
	logic serial_valid_i = 1'b0, memory_full_i = 1'b0;
	logic [15:0] temp_value_i = 16'h0000, serial_value_i = 16'h0000;
	logic [7:0] rdata_o;
	logic mission_active_o, recording_o, conversions_on_o, log_temperature_o;
	logic log_serial_input_o, temp_wide_format_o, serial_wide_format_o, wrap_when_full_o;
	logic osc_enable_o, sample_unit_seconds_o;
	logic [3:0] alarm_flags_o;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	logger_mission_control_regs logger_mission_control_regs_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .start_mission_i(start_mission_i),
		.stop_mission_i(stop_mission_i), .forced_conv_i(forced_conv_i),
		.clear_flags_i(clear_flags_i), .temp_valid_i(temp_valid_i), .temp_value_i(temp_value_i),
		.serial_valid_i(serial_valid_i), .serial_value_i(serial_value_i),
		.memory_full_i(memory_full_i), .mission_active_o(mission_active_o),
		.recording_o(recording_o), .conversions_on_o(conversions_on_o),
		.log_temperature_o(log_temperature_o), .log_serial_input_o(log_serial_input_o),
		.temp_wide_format_o(temp_wide_format_o), .serial_wide_format_o(serial_wide_format_o),
		.wrap_when_full_o(wrap_when_full_o), .osc_enable_o(osc_enable_o),
		.sample_unit_seconds_o(sample_unit_seconds_o), .alarm_flags_o(alarm_flags_o)
	);
	always #2 clk_i = ~clk_i;
	// ==========
	// Helpers drive at a rising edge and return 1 ns after their last edge
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask
	// Command index: 0 start, 1 stop, 2 forced conversion, 3 clear flags
	task automatic cmd(input int k);
		@(posedge clk_i);
		{clear_flags_i, forced_conv_i, stop_mission_i, start_mission_i} <= 4'(1 << k);
		@(posedge clk_i);
		{clear_flags_i, forced_conv_i, stop_mission_i, start_mission_i} <= 4'h0;
		#1;
	endtask
	task automatic smp(input logic ser, input logic [15:0] v);
		@(posedge clk_i);
		temp_value_i <= v;
		serial_value_i <= v;
		temp_valid_i <= !ser;
		serial_valid_i <= ser;
		@(posedge clk_i);
		{temp_valid_i, serial_valid_i} <= 2'b00;
		#1;
	endtask
	// ==========
	// Scenarios
	task automatic t_regs;
		logic [7:0] hi [4] = '{8'h03, 8'hff, 8'h03, 8'hff};
		logic [7:0] lo [4] = '{8'h00, 8'hfc, 8'h00, 8'hc0};
		for (int i = 0; i < 4; i++)
		begin
			rd(TEMP_ALARM_ENABLE_CTRL_OFFS + 10'(i), lo[i]);
			wr(TEMP_ALARM_ENABLE_CTRL_OFFS + 10'(i), 8'hff);
			rd(TEMP_ALARM_ENABLE_CTRL_OFFS + 10'(i), hi[i]);
			wr(TEMP_ALARM_ENABLE_CTRL_OFFS + 10'(i), 8'h00);
			rd(TEMP_ALARM_ENABLE_CTRL_OFFS + 10'(i), lo[i]);
		end
		rd(10'h3ff, 8'h00);
		wr(MISSION_CONTROL_OFFS, 8'hff);
		cyc(1);
		chk({3'h0, log_temperature_o, log_serial_input_o, temp_wide_format_o,
			serial_wide_format_o, wrap_when_full_o}, 8'h1f);
		wr(CLOCK_CONTROL_OFFS, 8'h02);
		cyc(1);
		chk({6'h00, sample_unit_seconds_o, osc_enable_o}, 8'h02);
		wr(CLOCK_CONTROL_OFFS, 8'h01);
		cyc(1);
		chk({6'h00, sample_unit_seconds_o, osc_enable_o}, 8'h01);
		wr(CLOCK_CONTROL_OFFS, 8'h00);
		wr(MISSION_CONTROL_OFFS, 8'h00);
		cmd(0);
		cyc(3);
		chk({7'h00, mission_active_o}, 8'h00);
		cmd(2);
		rd(CLOCK_CONTROL_OFFS, 8'h01);
	endtask
	task automatic t_mission;
		wr(CLOCK_CONTROL_OFFS, 8'h01);
		rd(CLOCK_CONTROL_OFFS, 8'h01);
		wr(TEMP_ALARM_ENABLE_CTRL_OFFS, 8'h03);
		wr(DATA_ALARM_ENABLE_CTRL_OFFS, 8'h03);
		wr(TEMP_LOW_THRESH_OFFS, 8'h40);
		wr(TEMP_HIGH_THRESH_OFFS, 8'hc0);
		wr(DATA_LOW_THRESH_OFFS, 8'h40);
		wr(DATA_HIGH_THRESH_OFFS, 8'hc0);
		wr(MISSION_CONTROL_OFFS, 8'h03);
		cmd(0);
		cyc(2);
		chk({7'h00, mission_active_o}, 8'h01);
		wr(MISSION_CONTROL_OFFS, 8'h10);
		rd(MISSION_CONTROL_OFFS, 8'hc3);
		wr(TEMP_ALARM_ENABLE_CTRL_OFFS, 8'h00);
		rd(TEMP_ALARM_ENABLE_CTRL_OFFS, 8'h03);
		smp(1'b0, 16'h4100);
		chk({4'h0, alarm_flags_o}, 8'h00);
		smp(1'b0, 16'h40ff);
		chk({4'h0, alarm_flags_o}, 8'h01);
		smp(1'b0, 16'hc000);
		chk({4'h0, alarm_flags_o}, 8'h03);
		smp(1'b1, 16'h40ff);
		chk({4'h0, alarm_flags_o}, 8'h07);
		smp(1'b1, 16'hc000);
		chk({4'h0, alarm_flags_o}, 8'h0f);
		rd(ALARM_STATUS_OFFS, 8'h7f);
		cmd(3);
		chk({4'h0, alarm_flags_o}, 8'h00);
		cmd(1);
		wr(TEMP_ALARM_ENABLE_CTRL_OFFS, 8'h00);
		wr(DATA_ALARM_ENABLE_CTRL_OFFS, 8'h00);
		cmd(0);
		smp(1'b0, 16'h0000);
		smp(1'b1, 16'hff00);
		chk({4'h0, alarm_flags_o}, 8'h00);
		cmd(1);
	endtask
	task automatic t_wait_alarm;
		wr(TEMP_ALARM_ENABLE_CTRL_OFFS, 8'h01);
		wr(MISSION_CONTROL_OFFS, 8'h21);
		cmd(0);
		smp(1'b0, 16'h8000);
		cyc(3);
		chk({6'h00, recording_o, conversions_on_o}, 8'h01);
		smp(1'b0, 16'h2000);
		cyc(3);
		chk({6'h00, recording_o, conversions_on_o}, 8'h03);
		@(posedge clk_i);
		memory_full_i <= 1'b1;
		cyc(3);
		chk({6'h00, recording_o, conversions_on_o}, 8'h00);
		@(posedge clk_i);
		memory_full_i <= 1'b0;
		cmd(1);
		wr(MISSION_CONTROL_OFFS, 8'h11);
		cmd(0);
		@(posedge clk_i);
		memory_full_i <= 1'b1;
		cyc(3);
		chk({6'h00, recording_o, conversions_on_o}, 8'h03);
		@(posedge clk_i);
		memory_full_i <= 1'b0;
		cmd(1);
		wr(CLOCK_CONTROL_OFFS, 8'h00);
		cyc(1);
		chk({7'h00, osc_enable_o}, 8'h00);
	endtask
	// ==========
	// Sequence, watchdog and verdict
	task automatic end_of_test;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_regs();
		$display("t_regs done");
		t_mission();
		$display("t_mission done");
		t_wait_alarm();
		$display("t_wait_alarm done");
		end_of_test();
	end
endmodule
